// File: rtl/rmc_pkg.sv
// package of constants and types for the receiver mode and bank control block
// assumes a single digital clock domain; all pins are synchronised inside the block
package rmc_pkg;

  // ----------------------------------------------------------------
  // command byte layout
  // ----------------------------------------------------------------
  localparam int CMD_COUNT_HI = 7;  // count code upper bit
  localparam int CMD_COUNT_LO = 6;  // count code lower bit
  localparam int CMD_ADDR_HI = 5;   // start address upper bit
  localparam int CMD_ADDR_LO = 1;   // start address lower bit
  localparam int CMD_DIR_BIT = 0;   // 1 = write, 0 = read
  localparam int ADDR_W = 5;        // register address width
  localparam int BYTE_BITS = 8;     // bits in one transfer unit
  localparam logic [3:0] BYTE_DONE = 4'h8;  // rise count at a full byte

  // ----------------------------------------------------------------
  // timing and reset values
  // ----------------------------------------------------------------
  localparam int ON_UNIT_CYCLES = 512;           // digital clocks per on-time step
  localparam logic RST_BANK_A_ACTIVE = 1'b1;     // bank A active after power-on
  localparam logic [1:0] RST_SYNC_HIGH = 2'h3;   // select line rests pulled high

  // ----------------------------------------------------------------
  // operating states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_STANDBY = 5'h01,  // pure standby
    ST_LVD     = 5'h02,  // low-voltage detect states
    ST_CONFIG  = 5'h04,  // configuration, held for as long as select stays low
    ST_RX_ON   = 5'h08,  // receiver on with the active bank
    ST_RX_OFF  = 5'h10   // receiver off between wakeups
  } rmc_mode_t;

endpackage : rmc_pkg

// File: rtl/rmc_ctrl.sv
// mode sequencer, SPI configuration slave and bank switching of the receiver
// assumes pins arrive asynchronously; message_active comes from the data manager on sys_clk
module rmc_ctrl #(
  parameter int ON_UNIT_CYCLES = rmc_pkg::ON_UNIT_CYCLES,  // shorten in simulation
  parameter int OFF_CNT_W = 4                                // width of strobe tick counter
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // host pins
  input wire logic config_select_n,
  input wire logic spi_enable_n,
  input wire logic strobe_pin,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // strobe oscillator clock from the timing capacitor circuit
  input wire logic strobe_osc_clk,
  // configuration bits
  input wire logic low_voltage_detect_enable,
  input wire logic strobe_osc_enable,
  input wire logic bank_a_select,
  input wire logic bank_b_select,
  input wire logic [3:0] on_time_field_a,
  input wire logic [3:0] on_time_field_b,
  input wire logic [2:0] off_time_field,
  // data manager status
  input wire logic message_active,
  // status
  output rmc_pkg::rmc_mode_t mode_state,
  output logic bank_a_active,
  output logic receiver_on
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] cs_sync;       // select synchroniser
    logic [1:0] stb_sync;      // strobe synchroniser
    logic [1:0] sclk_sync;     // serial clock synchroniser
    logic [1:0] mosi_sync;     // serial data synchroniser
    logic [1:0] sen_sync;      // spi enable synchroniser
    logic [1:0] osc_sync;      // oscillator clock synchroniser
    logic cs_prev;             // edge history
    logic stb_prev;
    logic sclk_prev;
    logic osc_prev;
    rmc_pkg::rmc_mode_t state;
    logic first_byte;          // next full byte is a command
    logic [3:0] bit_cnt;       // rising edges seen in this byte
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic [rmc_pkg::ADDR_W-1:0] addr;
    logic [rmc_pkg::ADDR_W-1:0] step;
    logic [3:0] remaining;     // data bytes still allowed
    logic dir_write;
    logic accessed;            // a data byte moved in this access
    logic bank_a_active;
    logic [15:0] on_cnt;
    logic [OFF_CNT_W-1:0] off_cnt;
    logic [31:0][7:0] mem;     // configuration register image
    logic miso;
    logic miso_oe;
    logic receiver_on;
  } rmc_regs_t;

  localparam rmc_regs_t RST = '{
    cs_sync: rmc_pkg::RST_SYNC_HIGH,
    cs_prev: 1'b1,
    state: rmc_pkg::ST_STANDBY,
    bank_a_active: rmc_pkg::RST_BANK_A_ACTIVE,
    default: '0
  };

  rmc_regs_t r;        // registered state
  rmc_regs_t next_r;   // next state

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // count code to number of registers, also the address step
  function automatic logic [3:0] count_decode(input logic [1:0] code);
    count_decode = 4'h1 << code;
  endfunction

  // on-time load for the bank about to run
  function automatic logic [15:0] on_load(input logic [3:0] field);
    logic [15:0] units;
    units = (field == 4'h0) ? 16'h0001 : {12'h000, field};
    on_load = 16'(units * ON_UNIT_CYCLES);
  endfunction

  // only second synchroniser stages feed logic below
  logic cs_n_s, stb_s, sclk_s, mosi_s, sen_n_s, osc_s;
  logic cs_rise, cs_fall, stb_fall, sclk_rise, sclk_fall, osc_rise;
  logic both_sel, spi_live;
  assign cs_n_s = r.cs_sync[1];
  assign stb_s = r.stb_sync[1];
  assign sclk_s = r.sclk_sync[1];
  assign mosi_s = r.mosi_sync[1];
  assign sen_n_s = r.sen_sync[1];
  assign osc_s = r.osc_sync[1];
  assign cs_rise = cs_n_s & ~r.cs_prev;
  assign cs_fall = ~cs_n_s & r.cs_prev;
  assign stb_fall = ~stb_s & r.stb_prev;
  assign sclk_rise = sclk_s & ~r.sclk_prev;
  assign sclk_fall = ~sclk_s & r.sclk_prev;
  assign osc_rise = osc_s & ~r.osc_prev;
  assign both_sel = bank_a_select & bank_b_select;
  assign spi_live = (r.state == rmc_pkg::ST_CONFIG) & ~sen_n_s;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    // two-flop synchronisers for every pin
    next_r.cs_sync = {r.cs_sync[0], config_select_n};
    next_r.stb_sync = {r.stb_sync[0], strobe_pin};
    next_r.sclk_sync = {r.sclk_sync[0], sclk};
    next_r.mosi_sync = {r.mosi_sync[0], mosi};
    next_r.sen_sync = {r.sen_sync[0], spi_enable_n};
    next_r.osc_sync = {r.osc_sync[0], strobe_osc_clk};
    next_r.cs_prev = cs_n_s;
    next_r.stb_prev = stb_s;
    next_r.sclk_prev = sclk_s;
    next_r.osc_prev = osc_s;

    // serial engine: only while configuring
    if (cs_fall) begin
      next_r.first_byte = 1'b1;
      next_r.bit_cnt = 4'h0;
      next_r.accessed = 1'b0;
      next_r.remaining = 4'h0;
    end else if (spi_live) begin
      if (sclk_rise && r.bit_cnt != rmc_pkg::BYTE_DONE) begin
        // data sampled on the rising edge, msb first
        next_r.shift_in = {r.shift_in[6:0], mosi_s};
        next_r.bit_cnt = r.bit_cnt + 4'h1;
      end
      if (sclk_fall) begin
        if (r.bit_cnt == rmc_pkg::BYTE_DONE) begin
          // a full byte is taken on the eighth falling edge
          next_r.bit_cnt = 4'h0;
          if (r.first_byte) begin
            // command decode
            next_r.first_byte = 1'b0;
            next_r.addr = r.shift_in[rmc_pkg::CMD_ADDR_HI:rmc_pkg::CMD_ADDR_LO];
            next_r.dir_write = r.shift_in[rmc_pkg::CMD_DIR_BIT];
            next_r.remaining = count_decode(r.shift_in[rmc_pkg::CMD_COUNT_HI:rmc_pkg::CMD_COUNT_LO]);
            next_r.step = 5'(count_decode(r.shift_in[rmc_pkg::CMD_COUNT_HI:rmc_pkg::CMD_COUNT_LO]));
            // read data leaves at once; a write never drives the line
            next_r.shift_out = r.mem[r.shift_in[rmc_pkg::CMD_ADDR_HI:rmc_pkg::CMD_ADDR_LO]];
          end else if (r.remaining != 4'h0) begin
            if (r.dir_write) begin
              next_r.mem[r.addr] = r.shift_in;
            end
            // advance by the access count, as the address logic was built
            next_r.addr = r.addr + r.step;
            next_r.remaining = r.remaining - 4'h1;
            next_r.shift_out = r.mem[5'(r.addr + r.step)];
            next_r.accessed = 1'b1;
          end
        end else begin
          // mid-byte: move the next read bit out
          next_r.shift_out = {r.shift_out[6:0], 1'b0};
        end
      end
    end
    // a partial byte at the end of an access simply dies here
    next_r.miso = next_r.shift_out[7];
    next_r.miso_oe = spi_live & ~next_r.first_byte & ~next_r.dir_write & (next_r.remaining != 4'h0);

    // mode sequencer
    unique case (r.state)
      rmc_pkg::ST_STANDBY, rmc_pkg::ST_LVD: begin
        // incoming traffic ignored; only select low with strobe high leaves
        if (!cs_n_s && stb_s) begin
          next_r.state = rmc_pkg::ST_CONFIG;
        end else begin
          next_r.state = low_voltage_detect_enable ? rmc_pkg::ST_LVD : rmc_pkg::ST_STANDBY;
        end
      end
      rmc_pkg::ST_CONFIG: begin
        // registers and receiver power are left alone here
        if (cs_n_s) begin
          // bank choice takes effect on select release
          if (!bank_b_select) begin
            next_r.bank_a_active = 1'b1;
          end else if (!bank_a_select) begin
            next_r.bank_a_active = 1'b0;
          end else if (r.accessed) begin
            next_r.bank_a_active = 1'b1;  // alternation restarts with A
          end
          if (stb_s) begin
            next_r.state = rmc_pkg::ST_RX_ON;
            next_r.receiver_on = 1'b1;
            next_r.on_cnt = on_load(next_r.bank_a_active ? on_time_field_a : on_time_field_b);
          end else if (strobe_osc_enable) begin
            next_r.state = rmc_pkg::ST_RX_OFF;
            next_r.receiver_on = 1'b0;
            next_r.off_cnt = OFF_CNT_W'({1'b0, off_time_field} + 4'h1);
          end else begin
            // host holds strobe low: back to the low-power states
            next_r.state = low_voltage_detect_enable ? rmc_pkg::ST_LVD : rmc_pkg::ST_STANDBY;
          end
        end
      end
      rmc_pkg::ST_RX_ON: begin
        if (r.on_cnt != 16'h0000) begin
          next_r.on_cnt = r.on_cnt - 16'h0001;
        end
        if (!cs_n_s) begin
          // select low resets the sequencer into configuration
          next_r.state = rmc_pkg::ST_CONFIG;
        end else if (message_active || stb_s) begin
          // a message or a forced-high strobe keeps this state
          next_r.state = rmc_pkg::ST_RX_ON;
        end else if (!strobe_osc_enable || r.on_cnt == 16'h0000) begin
          // strobe low or on period over: receiver off
          next_r.state = rmc_pkg::ST_RX_OFF;
          next_r.receiver_on = 1'b0;
          next_r.off_cnt = OFF_CNT_W'({1'b0, off_time_field} + 4'h1);
          if (strobe_osc_enable && both_sel) begin
            next_r.bank_a_active = ~r.bank_a_active;
          end
        end
      end
      rmc_pkg::ST_RX_OFF: begin
        if (!cs_n_s) begin
          next_r.state = rmc_pkg::ST_CONFIG;
        end else if (stb_s || (strobe_osc_enable && osc_rise && r.off_cnt == OFF_CNT_W'(1))) begin
          // wake with the bank currently shown by status
          next_r.state = rmc_pkg::ST_RX_ON;
          next_r.receiver_on = 1'b1;
          next_r.on_cnt = on_load(r.bank_a_active ? on_time_field_a : on_time_field_b);
        end else if (strobe_osc_enable && osc_rise && r.off_cnt != '0) begin
          // off time counted in strobe oscillator periods; held while strobe_osc_enable is low
          next_r.off_cnt = r.off_cnt - OFF_CNT_W'(1);
        end
      end
      default: begin
        next_r.state = rmc_pkg::ST_STANDBY;
      end
    endcase

    // pin-driven alternation toggles on each strobe falling edge in the receiver on and off states
    if (!strobe_osc_enable && both_sel && stb_fall &&
        (r.state == rmc_pkg::ST_RX_ON || r.state == rmc_pkg::ST_RX_OFF)) begin
      next_r.bank_a_active = ~r.bank_a_active;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r <= RST;  // power-on lands in standby
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flops
  assign miso = r.miso;
  assign miso_oe = r.miso_oe;
  assign mode_state = r.state;
  assign bank_a_active = r.bank_a_active;
  assign receiver_on = r.receiver_on;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_cfg_hold;
    r.state == rmc_pkg::ST_CONFIG && !cs_n_s |=> r.state == rmc_pkg::ST_CONFIG;
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config state left while select low");

  // select release always ends configuration, whatever the strobe does
  property p_cfg_exit;
    r.state == rmc_pkg::ST_CONFIG && cs_rise |=> r.state != rmc_pkg::ST_CONFIG;
  endproperty
  a_cfg_exit: assert property (p_cfg_exit) else $error("config state kept after select release");

  property p_standby_hold;
    (r.state == rmc_pkg::ST_STANDBY || r.state == rmc_pkg::ST_LVD) && !(!cs_n_s && stb_s)
      |=> (r.state == rmc_pkg::ST_STANDBY || r.state == rmc_pkg::ST_LVD);
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("standby left without exit pattern");

  property p_lvd_select;
    r.state == rmc_pkg::ST_CONFIG && cs_n_s && !stb_s && !strobe_osc_enable
      |=> r.state == ($past(low_voltage_detect_enable) ? rmc_pkg::ST_LVD : rmc_pkg::ST_STANDBY);
  endproperty
  a_lvd_select: assert property (p_lvd_select) else $error("wrong low-power state chosen");

  property p_no_drive_on_write;
    r.miso_oe |-> !r.dir_write && r.state == rmc_pkg::ST_CONFIG;
  endproperty
  a_no_drive_on_write: assert property (p_no_drive_on_write) else $error("miso driven outside a read");

  property p_cmd_decode;
    spi_live && !cs_fall && sclk_fall && r.first_byte && r.bit_cnt == rmc_pkg::BYTE_DONE
      |=> r.addr == $past(r.shift_in[5:1]) && r.dir_write == $past(r.shift_in[0])
          && r.remaining == (4'h1 << $past(r.shift_in[7:6])) && !r.first_byte;
  endproperty
  a_cmd_decode: assert property (p_cmd_decode) else $error("command byte decoded wrongly");

  property p_addr_step;
    spi_live && !cs_fall && sclk_fall && !r.first_byte && r.bit_cnt == rmc_pkg::BYTE_DONE && r.remaining != 4'h0
      |=> r.addr == 5'($past(r.addr) + $past(r.step)) && r.remaining == $past(r.remaining) - 4'h1;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address not advanced by count");

  property p_bank_direct;
    r.state == rmc_pkg::ST_CONFIG && cs_n_s && !bank_b_select |=> r.bank_a_active;
  endproperty
  a_bank_direct: assert property (p_bank_direct) else $error("bank A not chosen on release");

  // the strobe usually falls while the receiver is still on, so both states are watched
  property p_bank_toggle;
    !strobe_osc_enable && both_sel && stb_fall && (r.state == rmc_pkg::ST_RX_ON || r.state == rmc_pkg::ST_RX_OFF)
      |=> r.bank_a_active != $past(r.bank_a_active);
  endproperty
  a_bank_toggle: assert property (p_bank_toggle) else $error("bank not toggled on strobe fall");

  property p_msg_hold;
    r.state == rmc_pkg::ST_RX_ON && message_active && cs_n_s |=> r.state == rmc_pkg::ST_RX_ON [*1] ##0 r.receiver_on;
  endproperty
  a_msg_hold: assert property (p_msg_hold) else $error("on state ended during a message");

  property p_rx_kept_in_cfg;
    r.state == rmc_pkg::ST_CONFIG ##1 r.state == rmc_pkg::ST_CONFIG |-> $stable(r.receiver_on);
  endproperty
  a_rx_kept_in_cfg: assert property (p_rx_kept_in_cfg) else $error("receiver power changed in config");

  property p_strobe_off;
    r.state == rmc_pkg::ST_RX_ON && !strobe_osc_enable && !stb_s && !message_active && cs_n_s
      |=> !r.receiver_on ##1 r.state == rmc_pkg::ST_RX_OFF || r.state == rmc_pkg::ST_CONFIG;
  endproperty
  a_strobe_off: assert property (p_strobe_off) else $error("strobe low did not turn receiver off");

endmodule // rmc_ctrl

// File: tb/rmc_host_model.sv
// host controller model: SPI master driving the configuration port
// assumes sys_clk is the device clock; sclk half period is four sys_clk cycles
module rmc_host_model (
  // clock
  input wire logic sys_clk,
  // select pins
  output logic config_select_n,
  output logic spi_enable_n,
  // spi link
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  // select rests pulled high at power-up; the link clock stands low outside frames
  initial begin
    config_select_n = 1'b1;
    spi_enable_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // ----------------------------------------------------------------
  // link tasks
  // ----------------------------------------------------------------
  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // both selects move together; six cycles cover the pin synchronisers
  task automatic select(input logic lvl);
    config_select_n <= lvl;
    spi_enable_n <= lvl;
    wait_clk(6);
  endtask

  // one unit, msb first; a short count leaves a partial unit on the wire
  task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      mosi <= tx[i];
      wait_clk(4);
      sclk <= 1'b1;
      rx[i] = miso; // read data taken at the rising edge
      wait_clk(4);
      sclk <= 1'b0;
    end
    // a released data line must not keep showing the last bit
    mosi <= ~tx[8 - nbits];
    wait_clk(4);
  endtask

  // one-cycle select pulse: resets the sequencer only, spi stays disabled
  task automatic seq_reset;
    config_select_n <= 1'b0;
    wait_clk(1);
    config_select_n <= 1'b1;
    wait_clk(6);
  endtask

  // whole access: command first, then data units, then any partial unit
  task automatic access(input logic [7:0] cmd, input int nb, input logic [7:0] w0, input logic [7:0] w1,
                        input int tail, output logic [7:0] r0, output logic [7:0] r1);
    logic [7:0] unused;
    r0 = 8'h00;
    r1 = 8'h00;
    select(1'b0);
    shift(cmd, 8, unused);
    if (nb > 0) begin
      shift(w0, 8, r0);
    end
    if (nb > 1) begin
      shift(w1, 8, r1);
    end
    if (tail > 0) begin
      shift(8'hFF, tail, unused);
    end
    wait_clk(4);
    select(1'b1); // select pulsed high between accesses
  endtask
endmodule // rmc_host_model

// File: tb/tb.sv
// self-checking bench of the receiver mode and bank control block
// assumes the host model drives the select and link pins; the bench drives the rest
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int UNIT = 4; // shortened on-time step
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic strobe_pin = 1'b0;
  logic strobe_osc_clk = 1'b0;
  logic low_voltage_detect_enable = 1'b0;
  logic strobe_osc_enable = 1'b0;
  logic bank_a_select = 1'b0;
  logic bank_b_select = 1'b0;
  logic [3:0] on_time_field_a = 4'h1;
  logic [3:0] on_time_field_b = 4'h3;
  logic [2:0] off_time_field = 3'h1;
  logic message_active = 1'b0;
  logic [2:0] osc_div = 3'h0;
  logic config_select_n, spi_enable_n, sclk, mosi, miso, miso_oe, bank_a_active, receiver_on;
  rmc_pkg::rmc_mode_t mode_state;
  int failures = 0;
  int comparisons = 0;
  int oe_cycles = 0; // cycles in which the device drove miso

  // 10 MHz clock; strobe oscillator stand-in at one sixteenth of it
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    osc_div <= osc_div + 3'h1;
    if (osc_div == 3'h7) begin
      strobe_osc_clk <= ~strobe_osc_clk;
    end
  end

  // miso enable monitor; scenarios compare snapshots taken around an access
  always @(posedge sys_clk) begin
    if (miso_oe) begin
      oe_cycles <= oe_cycles + 1;
    end
  end

  rmc_ctrl #(.ON_UNIT_CYCLES(UNIT), .OFF_CNT_W(4)) u_rmc_ctrl (
    .sys_clk(sys_clk), .rstn(rstn), .config_select_n(config_select_n), .spi_enable_n(spi_enable_n),
    .strobe_pin(strobe_pin), .sclk(sclk), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .strobe_osc_clk(strobe_osc_clk), .low_voltage_detect_enable(low_voltage_detect_enable),
    .strobe_osc_enable(strobe_osc_enable), .bank_a_select(bank_a_select), .bank_b_select(bank_b_select),
    .on_time_field_a(on_time_field_a), .on_time_field_b(on_time_field_b), .off_time_field(off_time_field),
    .message_active(message_active), .mode_state(mode_state), .bank_a_active(bank_a_active),
    .receiver_on(receiver_on));

  rmc_host_model u_rmc_host_model (
    .sys_clk(sys_clk), .config_select_n(config_select_n), .spi_enable_n(spi_enable_n),
    .sclk(sclk), .mosi(mosi), .miso(miso));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // bounded wait for the receiver level; n returns the cycles spent
  task automatic wait_rx(input logic lvl, output int n);
    n = 0;
    while (receiver_on !== lvl) begin
      wait_clk(1);
      n++;
      if (n > 600) begin
        failures++;
        $display("ERROR receiver_on wait expected %b seen %b", lvl, receiver_on);
        tally_and_finish();
      end
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check("mode_state", 8'h01, {3'h0, mode_state});
    check("bank_a_active", 8'h01, {7'h0, bank_a_active});
    check("receiver_on", 8'h00, {7'h0, receiver_on});
    $display("test reset done");
  endtask

  // traffic with the strobe low is ignored; config exit picks standby or detect
  task automatic t_standby;
    logic [7:0] r0, r1;
    u_rmc_host_model.access(8'h13, 1, 8'hC3, 8'h00, 0, r0, r1);
    check("mode_state", 8'h01, {3'h0, mode_state});
    for (int k = 1; k >= 0; k--) begin
      low_voltage_detect_enable <= k[0];
      strobe_pin <= 1'b1;
      u_rmc_host_model.select(1'b0);
      check("mode_state", 8'h04, {3'h0, mode_state});
      strobe_pin <= 1'b0;
      wait_clk(6);
      check("mode_state", 8'h04, {3'h0, mode_state});
      u_rmc_host_model.select(1'b1);
      check("mode_state", k ? 8'h02 : 8'h01, {3'h0, mode_state});
    end
    $display("test standby done");
  endtask

  // counts, address steps, discarded units, read back through miso
  task automatic t_spi;
    logic [7:0] r0, r1;
    int oe0;
    logic [7:0] zero_cmd [3] = '{8'h18, 8'h0E, 8'h12};
    strobe_pin <= 1'b1;
    for (int c = 1; c < 4; c++) begin
      oe0 = oe_cycles;
      u_rmc_host_model.access({c[1:0], 5'h10, 1'b1}, 2, 8'h30 + 8'(c), 8'h40 + 8'(c), 0, r0, r1);
      check("miso_oe on write", 8'h00, 8'(oe_cycles - oe0));
      oe0 = oe_cycles;
      u_rmc_host_model.access({c[1:0], 5'h10, 1'b0}, 2, 8'h00, 8'h00, 0, r0, r1);
      check("miso_oe on read", 8'h01, {7'h0, oe_cycles != oe0});
      check("read first", 8'h30 + 8'(c), r0);
      check("read stepped", 8'h40 + 8'(c), r1);
    end
    u_rmc_host_model.access(8'h17, 2, 8'h5A, 8'hA5, 0, r0, r1);
    u_rmc_host_model.access(8'h0F, 0, 8'h00, 8'h00, 5, r0, r1);
    u_rmc_host_model.access(8'h56, 2, 8'h00, 8'h00, 0, r0, r1);
    check("read single", 8'h5A, r0);
    foreach (zero_cmd[i]) begin
      u_rmc_host_model.access(zero_cmd[i], 1, 8'h00, 8'h00, 0, r0, r1);
      check("untouched register", 8'h00, r0);
    end
    check("mode_state", 8'h08, {3'h0, mode_state});
    $display("test spi done");
  endtask

  // direct and strobe pin control of banks and receiver power
  task automatic t_banks;
    int n;
    logic [7:0] r0, r1;
    bank_b_select <= 1'b1;
    u_rmc_host_model.select(1'b0);
    check("receiver_on", 8'h01, {7'h0, receiver_on});
    u_rmc_host_model.select(1'b1);
    check("bank_a_active", 8'h00, {7'h0, bank_a_active});
    strobe_pin <= 1'b0;
    wait_rx(1'b0, n);
    check("mode_state", 8'h10, {3'h0, mode_state});
    strobe_pin <= 1'b1;
    wait_rx(1'b1, n);
    bank_a_select <= 1'b1;
    u_rmc_host_model.access(8'h03, 1, 8'h11, 8'h00, 0, r0, r1);
    check("bank_a_active", 8'h01, {7'h0, bank_a_active});
    for (int k = 0; k < 3; k++) begin
      strobe_pin <= k[0];
      wait_clk(6);
      check("bank_a_active", (k == 2) ? 8'h01 : 8'h00, {7'h0, bank_a_active});
    end
    strobe_pin <= 1'b1;
    wait_rx(1'b1, n);
    u_rmc_host_model.seq_reset();
    check("mode_state", 8'h08, {3'h0, mode_state});
    message_active <= 1'b1;
    strobe_pin <= 1'b0;
    wait_clk(20);
    check("receiver_on", 8'h01, {7'h0, receiver_on});
    message_active <= 1'b0;
    wait_rx(1'b0, n);
    $display("test banks done");
  endtask

  // oscillator timed alternation; on length follows each bank's own field
  task automatic t_osc;
    int n, len1, len2;
    logic b1;
    logic [7:0] r0, r1;
    strobe_osc_enable <= 1'b1;
    strobe_pin <= 1'b1;
    u_rmc_host_model.access(8'h03, 1, 8'h22, 8'h00, 0, r0, r1);
    strobe_pin <= 1'b0;
    wait_rx(1'b0, n);
    wait_rx(1'b1, n);
    b1 = bank_a_active;
    wait_rx(1'b0, len1);
    wait_rx(1'b1, n);
    check("bank_a_active", {7'h0, ~b1}, {7'h0, bank_a_active});
    wait_rx(1'b0, len2);
    check("on length difference", b1 ? 8'hF8 : 8'h08, 8'(len1 - len2));
    $display("test osc done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    wait_clk(3);
    rstn <= 1'b1;
    wait_clk(2);
    t_reset();
    t_standby();
    t_spi();
    t_banks();
    t_osc();
    tally_and_finish();
  end
endmodule // tb
